// ===== hdl/rx_cond_map.vh
`ifndef RX_COND_MAP_VH
`define RX_COND_MAP_VH

// Register indices; byte address is four times the index
`define IDX_PATTERN_CFG   12'h0123
`define IDX_COND_BASE     12'h0360
`define IDX_USER_BASE     12'h0380
`define IDX_SIGCTL_BASE   12'h03A0
`define IDX_SUBST_BASE    12'h03C0
`define IDX_SIGARR_BASE   12'h0500
// Region select is index bits 11:5
`define RGN_COND          7'h1B
`define RGN_USER          7'h1C
`define RGN_SIGCTL        7'h1D
`define RGN_SUBST         7'h1E
`define RGN_SIGARR        7'h28

// Field positions
`define BIT_PATTERN_TYPE  7
`define BIT_SUBST_EN      6
`define BIT_OH_EN         5
`define BIT_DEB_EN        4
`define RST_USER          8'hFF
`define RST_ZERO8         8'h00
`define RST_ZERO7         7'h00

// Conditioning codes
`define CC_PASS           4'h0
`define CC_INV_ALL        4'h1
`define CC_INV_EVEN       4'h2
`define CC_INV_ODD        4'h3
`define CC_USER           4'h4
`define CC_BUSY           4'h5
`define CC_VACANT         4'h6
`define CC_BUSY_TS        4'h7
`define CC_MOOF           4'h8
`define CC_MW_A           4'h9
`define CC_MW_MU          4'hA
`define CC_INV_MSB        4'hB
`define CC_INV_LOW7       4'hC
`define CC_PRBS           4'hD
`define CC_PASS2          4'hE
`define CC_DE_SLOT        4'hF

// Fixed octets
`define OCT_FF            8'hFF
`define OCT_AA            8'hAA
`define OCT_55            8'h55
`define OCT_MSB           8'h80
`define OCT_LOW7          8'h7F
`define OCT_MOOF          8'h1A
`define BUSY_TS_HEAD      3'h7

// Digital milliwatt sequences, first octet in the low byte
`define MW_ALAW           64'hB4A1_A1B4_3421_2134
`define MW_MULAW          64'h9E8B_8B9E_1E0B_0B1E

// Test pattern generators
`define PRBS15_SEED       15'h7FFF
`define QRTS_SEED         20'h0_0001
`define QRTS_ZERO_RUN     4'hE

`endif

// ===== hdl/rx_timeslot_conditioning.v
`timescale 1ns/1ns
`include "rx_cond_map.vh"

module rx_timeslot_conditioning (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [13:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  input  wire        i_frame_start,
  input  wire        i_oct_valid,
  input  wire [4:0]  i_ts_num,
  input  wire [7:0]  i_oct_data,
  input  wire        i_sig_valid,
  input  wire [3:0]  i_sig_abcd,
  input  wire [7:0]  i_de_data,
  output reg         o_pcm_valid,
  output reg  [4:0]  o_pcm_ts,
  output reg  [7:0]  o_pcm_data,
  output reg  [3:0]  o_pcm_sig,
  output reg         o_de_slot,
  output reg         o_sig_valid,
  output reg  [3:0]  o_sig_pin,
  output reg         o_oh_valid,
  output reg  [3:0]  o_oh_pin
);

  wire [11:0] idx    = i_paddr[13:2];
  wire [6:0]  region = idx[11:5];
  wire [4:0]  slot   = idx[4:0];
  wire        setup  = i_psel & ~i_penable;
  wire        access = i_psel & i_penable;
  wire        wr_en  = access & i_pwrite;

  reg         pattern_type_r;
  reg  [3:0]  cond_r  [0:31];
  reg  [7:0]  user_r  [0:31];
  reg  [6:0]  sigctl_r[0:31];
  reg  [6:0]  subst_r [0:31];
  reg  [3:0]  sigarr_r[0:31];
  reg  [3:0]  prev_r  [0:31];
  reg  [2:0]  mw_phase_r;
  reg  [14:0] prbs_r;
  reg  [19:0] qrts_r;
  reg  [3:0]  qrts_zeros_r;

  // Zero wait states; read data is latched in the setup cycle
  assign o_pready = 1'b1;

  // Per-slot registers and signaling debounce
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : slot_regs
      wire       hit  = wr_en & (slot == g);
      wire       samp = i_oct_valid & i_sig_valid & (i_ts_num == g);
      wire [1:0] ext  = sigctl_r[g][1:0];
      reg  [3:0] ext_mask;
      always @* begin
        case (ext)
          2'b01:   ext_mask = 4'hF;
          2'b10:   ext_mask = 4'hC;
          2'b11:   ext_mask = 4'h8;
          default: ext_mask = 4'h0;
        endcase
      end
      wire [3:0] sig_new = i_sig_abcd & ext_mask;
      always @(posedge i_clk) begin
        if (i_srst) begin
          cond_r[g]   <= `CC_PASS;
          user_r[g]   <= `RST_USER;
          sigctl_r[g] <= `RST_ZERO7;
          subst_r[g]  <= `RST_ZERO7;
          sigarr_r[g] <= 4'h0;
          prev_r[g]   <= 4'h0;
        end else begin
          if (hit && region == `RGN_COND)
            cond_r[g] <= i_pwdata[3:0];
          if (hit && region == `RGN_USER)
            user_r[g] <= i_pwdata[7:0];
          if (hit && region == `RGN_SIGCTL)
            sigctl_r[g] <= i_pwdata[6:0];
          if (hit && region == `RGN_SUBST)
            subst_r[g] <= i_pwdata[6:0];
          if (samp && ext != 2'b00) begin
            prev_r[g] <= sig_new;
            if (sigctl_r[g][`BIT_DEB_EN]) begin
              // Mismatch leaves the array as it was
              if (sig_new == prev_r[g])
                sigarr_r[g] <= sig_new;
            end else begin
              sigarr_r[g] <= sig_new;
            end
          end
        end
      end
    end
  endgenerate

  // Pattern type configuration register
  always @(posedge i_clk) begin
    if (i_srst)
      pattern_type_r <= 1'b0;
    else if (wr_en && idx == `IDX_PATTERN_CFG)
      pattern_type_r <= i_pwdata[`BIT_PATTERN_TYPE];
  end

  // APB read mux, unmapped reads give zero and an error
  reg [31:0] rd_nxt;
  reg        err_nxt;
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (region)
      `RGN_COND:   rd_nxt = {28'h000_0000, cond_r[slot]};
      `RGN_USER:   rd_nxt = {24'h00_0000, user_r[slot]};
      `RGN_SIGCTL: rd_nxt = {25'h000_0000, sigctl_r[slot]};
      `RGN_SUBST:  rd_nxt = {25'h000_0000, subst_r[slot]};
      `RGN_SIGARR: rd_nxt = {28'h000_0000, sigarr_r[slot]};
      default: begin
        if (idx == `IDX_PATTERN_CFG)
          rd_nxt = {24'h00_0000, pattern_type_r, 7'h00};
        else
          err_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_nxt;
      o_pslverr <= err_nxt;
    end
  end

  // Current slot's settings, sampled once with the octet strobe
  wire [3:0] code    = cond_r[i_ts_num];
  wire [6:0] ctl     = sigctl_r[i_ts_num];
  wire [6:0] sub     = subst_r[i_ts_num];
  wire [5:0] mw_lsb  = {mw_phase_r, 3'b000};
  wire [63:0] mw_a_seq  = `MW_ALAW;
  wire [63:0] mw_mu_seq = `MW_MULAW;
  wire [7:0] mw_a    = mw_a_seq[mw_lsb +: 8];
  wire [7:0] mw_mu   = mw_mu_seq[mw_lsb +: 8];
  wire       pat_adv = i_oct_valid & (code == `CC_PRBS);

  // Eight generator steps per octet, MSB first
  reg [14:0] prbs_nxt;
  reg [19:0] qrts_nxt;
  reg [3:0]  zeros_nxt;
  reg [7:0]  prbs_oct;
  reg [7:0]  qrts_oct;
  reg        qbit;
  integer    k;
  always @*  begin
    prbs_nxt  = prbs_r;
    qrts_nxt  = qrts_r;
    zeros_nxt = qrts_zeros_r;
    prbs_oct  = 8'h00;
    qrts_oct  = 8'h00;
    qbit      = 1'b0;
    for (k = 7; k >= 0; k = k - 1) begin
      prbs_oct[k] = prbs_nxt[14] ^ prbs_nxt[13];
      prbs_nxt    = {prbs_nxt[13:0], prbs_oct[k]};
      qbit        = qrts_nxt[19] ^ qrts_nxt[16];
      qrts_nxt    = {qrts_nxt[18:0], qbit};
      // QRTS forces a one after fourteen zeros in a row
      if (zeros_nxt >= `QRTS_ZERO_RUN) begin
        qrts_oct[k] = 1'b1;
        zeros_nxt   = 4'h0;
      end else begin
        qrts_oct[k] = qbit;
        zeros_nxt   = qbit ? 4'h0 : zeros_nxt + 4'h1;
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      prbs_r       <= `PRBS15_SEED;
      qrts_r       <= `QRTS_SEED;
      qrts_zeros_r <= 4'h0;
      mw_phase_r   <= 3'h0;
    end else begin
      if (pat_adv) begin
        prbs_r       <= prbs_nxt;
        qrts_r       <= qrts_nxt;
        qrts_zeros_r <= zeros_nxt;
      end
      if (i_frame_start)
        mw_phase_r <= mw_phase_r + 3'h1;
    end
  end

  // Octet conditioning
  reg [7:0] oct_nxt;
  always @* begin
    case (code)
      `CC_PASS, `CC_PASS2: oct_nxt = i_oct_data;
      `CC_INV_ALL:  oct_nxt = i_oct_data ^ `OCT_FF;
      `CC_INV_EVEN: oct_nxt = i_oct_data ^ `OCT_AA;
      `CC_INV_ODD:  oct_nxt = i_oct_data ^ `OCT_55;
      `CC_USER:     oct_nxt = user_r[i_ts_num];
      `CC_BUSY:     oct_nxt = `OCT_LOW7;
      `CC_VACANT:   oct_nxt = `OCT_FF;
      `CC_BUSY_TS:  oct_nxt = {`BUSY_TS_HEAD, i_ts_num};
      `CC_MOOF:     oct_nxt = `OCT_MOOF;
      `CC_MW_A:     oct_nxt = mw_a;
      `CC_MW_MU:    oct_nxt = mw_mu;
      `CC_INV_MSB:  oct_nxt = i_oct_data ^ `OCT_MSB;
      `CC_INV_LOW7: oct_nxt = i_oct_data ^ `OCT_LOW7;
      `CC_PRBS:     oct_nxt = pattern_type_r ? qrts_oct : prbs_oct;
      `CC_DE_SLOT:  oct_nxt = i_de_data;
      default:      oct_nxt = i_oct_data;
    endcase
  end

  // Signaling substitution scheme from control bits 3:2
  reg [3:0] sub_abcd;
  always @* begin
    case (ctl[3:2])
      2'b01:   sub_abcd = sub[3:0];
      2'b10:   sub_abcd = {sub[4], sub[5], sub[4], sub[5]};
      2'b11:   sub_abcd = {4{sub[6]}};
      default: sub_abcd = 4'hF;
    endcase
  end

  // Outputs registered; substitution reaches only the PCM side
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_pcm_valid <= 1'b0;
      o_pcm_ts    <= 5'h00;
      o_pcm_data  <= `RST_ZERO8;
      o_pcm_sig   <= 4'h0;
      o_de_slot   <= 1'b0;
      o_sig_valid <= 1'b0;
      o_sig_pin   <= 4'h0;
      o_oh_valid  <= 1'b0;
      o_oh_pin    <= 4'h0;
    end else begin
      o_pcm_valid <= i_oct_valid;
      o_sig_valid <= i_oct_valid;
      o_oh_valid  <= i_oct_valid & ctl[`BIT_OH_EN];
      o_de_slot   <= i_oct_valid & (code == `CC_DE_SLOT);
      if (i_oct_valid) begin
        o_pcm_ts   <= i_ts_num;
        o_pcm_data <= oct_nxt;
        o_pcm_sig  <= ctl[`BIT_SUBST_EN] ? sub_abcd : i_sig_abcd;
        o_sig_pin  <= sigarr_r[i_ts_num];
        o_oh_pin   <= ctl[`BIT_OH_EN] ? sigarr_r[i_ts_num] : 4'h0;
      end
    end
  end

endmodule

// ===== tb/rx_cond_props.sv
`timescale 1ns/1ns
module rx_cond_props (
  input wire        i_clk,
  input wire        i_srst,
  input wire        i_psel,
  input wire        i_penable,
  input wire [13:0] i_paddr,
  input wire        i_oct_valid,
  input wire [4:0]  i_ts_num,
  input wire        o_pslverr,
  input wire        o_pcm_valid,
  input wire [4:0]  o_pcm_ts,
  input wire [7:0]  o_pcm_data,
  input wire        o_de_slot,
  input wire        o_sig_valid,
  input wire        o_oh_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_pcm_latency: assert property (i_oct_valid |=> o_pcm_valid)
    else $error("pcm valid missing");
  a_no_spurious: assert property (!i_oct_valid |=> !o_pcm_valid)
    else $error("pcm valid without octet");
  a_slot_follow: assert property (i_oct_valid |=> o_pcm_ts == $past(i_ts_num))
    else $error("pcm slot wrong");
  a_data_hold: assert property (!i_oct_valid |=> $stable(o_pcm_data))
    else $error("pcm data moved");
  a_sig_paired: assert property (o_pcm_valid |-> o_sig_valid)
    else $error("signaling not paired");
  a_oh_gated: assert property (o_oh_valid |-> o_pcm_valid)
    else $error("overhead without octet");
  a_de_gated: assert property (o_de_slot |-> o_pcm_valid)
    else $error("de flag without octet");
  a_unmapped_err: assert property (i_psel && !i_penable && i_paddr[13:2] == 12'h0FFF
    |=> o_pslverr)
    else $error("unmapped not refused");
  a_user_ok: assert property (i_psel && !i_penable && i_paddr[13:7] == 7'h1C
    |=> !o_pslverr)
    else $error("user code refused");
  cover property (o_de_slot);
  cover property (o_oh_valid);
  cover property (o_pslverr);
endmodule
bind rx_timeslot_conditioning rx_cond_props rx_cond_props_i (.i_clk, .i_srst, .i_psel,
  .i_penable, .i_paddr, .i_oct_valid, .i_ts_num, .o_pslverr, .o_pcm_valid, .o_pcm_ts,
  .o_pcm_data, .o_de_slot, .o_sig_valid, .o_oh_valid);

// ===== tb/pcm_sink.sv
`timescale 1ns/1ns
// Backplane side: latches each conditioned octet as it passes
module pcm_sink (
  input  wire       i_clk,
  input  wire       i_valid,
  input  wire [7:0] i_data,
  input  wire [3:0] i_sig,
  input  wire [3:0] i_pin,
  input  wire       i_ohv,
  input  wire [3:0] i_oh,
  input  wire       i_de,
  output reg  [7:0] o_data,
  output reg  [3:0] o_sig,
  output reg  [3:0] o_pin,
  output reg        o_ohv,
  output reg  [3:0] o_oh,
  output reg        o_de
);
  always @(posedge i_clk) begin
    if (i_valid) begin
      o_data <= i_data;
      o_sig  <= i_sig;
      o_pin  <= i_pin;
      o_ohv  <= i_ohv;
      o_oh   <= i_oh;
      o_de   <= i_de;
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "rx_cond_map.vh"
module tb;
  reg i_clk = 0, i_srst = 1, psel = 0, pen = 0, pw = 0, fs = 0, ov = 0, sv = 0;
  reg [13:0] pa = 0;
  reg [31:0] pwd = 0, rd;
  reg [4:0] ts = 0;
  reg [7:0] od = 0, de = 0, a0, a1;
  reg [3:0] sg = 0;
  reg er;
  wire rdy, err, pv, dsl, sgv, ohv_w;
  wire [31:0] prd;
  wire [7:0] pd, s_d;
  wire [3:0] ps, sp, ohp, s_s, s_p, s_o;
  wire s_v, s_e;
  integer bad_count = 0, cmp_count = 0, cyc = 0, k, c;
  always #50 i_clk = ~i_clk;
  rx_timeslot_conditioning rx_timeslot_conditioning_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd),
    .o_pready(rdy), .o_prdata(prd), .o_pslverr(err), .i_frame_start(fs),
    .i_oct_valid(ov), .i_ts_num(ts), .i_oct_data(od), .i_sig_valid(sv),
    .i_sig_abcd(sg), .i_de_data(de), .o_pcm_valid(pv), .o_pcm_ts(), .o_pcm_data(pd),
    .o_pcm_sig(ps), .o_de_slot(dsl), .o_sig_valid(sgv), .o_sig_pin(sp),
    .o_oh_valid(ohv_w), .o_oh_pin(ohp));
  pcm_sink pcm_sink_i (.i_clk(i_clk), .i_valid(pv), .i_data(pd), .i_sig(ps),
    .i_pin(sp), .i_ohv(ohv_w), .i_oh(ohp), .i_de(dsl), .o_data(s_d), .o_sig(s_s),
    .o_pin(s_p), .o_ohv(s_v), .o_oh(s_o), .o_de(s_e));
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input w, input [11:0] idx, input [31:0] d);
    @(posedge i_clk);
    psel <= 1; pen <= 0; pw <= w; pa <= {idx, 2'b00}; pwd <= d;
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (rdy !== 1'b1);
    rd = prd;
    er = err;
    psel <= 0; pen <= 0;
  endtask
  task oct(input [4:0] t, input [7:0] d, input [3:0] s, input v);
    @(posedge i_clk);
    ov <= 1; ts <= t; od <= d; sg <= s; sv <= v;
    @(posedge i_clk);
    ov <= 0; sv <= 0;
    @(posedge i_clk);
    #1;
  endtask
  task frame;
    @(posedge i_clk);
    fs <= 1;
    @(posedge i_clk);
    fs <= 0;
  endtask
  function [7:0] expv(input [3:0] cc, input [7:0] d);
    case (cc)
      4'h1: expv = d ^ 8'hFF; 4'h2: expv = d ^ 8'hAA; 4'h3: expv = d ^ 8'h55;
      4'h4: expv = 8'h3C; 4'h5: expv = 8'h7F; 4'h6: expv = 8'hFF;
      4'h7: expv = {3'h7, 5'h05}; 4'h8: expv = 8'h1A;
      4'hB: expv = d ^ 8'h80; 4'hC: expv = d ^ 8'h7F; default: expv = d;
    endcase
  endfunction
  task t_regs;
    apb(0, 12'h0385, 0); chk(rd, 32'h0000_00FF, "user");
    apb(0, 12'h03A3, 0); chk(rd, 32'h0000_0000, "ctl");
    apb(0, 12'h0FFF, 0); chk(er, 1, "slverr");
    apb(1, 12'h039F, 32'h0000_00A7); apb(0, 12'h039F, 0); chk(rd, 32'h0000_00A7, "u31");
    apb(1, 12'h0385, 32'h0000_003C); apb(0, 12'h0385, 0); chk(rd, 32'h0000_003C, "u5");
    $display("regs done");
  endtask
  task t_codes;
    for (c = 0; c < 16; c = c + 1) begin
      if (c != 9 && c != 10 && c != 13 && c != 15) begin
        apb(1, 12'h0365, c); oct(5, 8'h5C, 0, 0);
        chk(s_d, expv(c, 8'h5C), "code");
      end
    end
    $display("codes done");
  endtask
  task t_mw;
    for (c = 0; c < 2; c = c + 1) begin
      apb(1, 12'h0361, c ? 32'h0000_000A : 32'h0000_0009);
      for (k = 0; k < 8; k = k + 1) begin
        oct(1, 8'h00, 0, 0);
        chk(s_d, c ? `MW_MULAW >> (8 * k) & 8'hFF : `MW_ALAW >> (8 * k) & 8'hFF, "mw");
        frame;
      end
    end
    $display("milliwatt done");
  endtask
  task t_pat;
    apb(1, 12'h0366, 32'h0000_000D);
    apb(1, 12'h0123, 32'h0000_0000); oct(6, 8'h00, 0, 0); a0 = s_d;
    apb(1, 12'h0123, 32'h0000_0080); oct(6, 8'h00, 0, 0); a1 = s_d;
    chk(a0 != a1 && (a0 | a1) != 0, 1, "pattern");
    apb(1, 12'h0367, 32'h0000_000F); de <= 8'hA5; oct(7, 8'h11, 0, 0);
    chk(s_e, 1, "deslot");
    chk(s_d, 8'hA5, "dedata");
    $display("pattern done");
  endtask
  task t_sig;
    apb(1, 12'h03A2, 32'h0000_0001);
    oct(2, 0, 4'h5, 1); oct(2, 0, 4'h5, 1); chk(s_p, 4'h5, "nodeb");
    chk(s_v, 0, "ohoff");
    apb(1, 12'h03A2, 32'h0000_0075); apb(1, 12'h03C2, 32'h0000_0009);
    oct(2, 0, 4'hA, 1); oct(2, 0, 4'h3, 1); chk(s_p, 4'h5, "deb1");
    oct(2, 0, 4'h3, 1); chk(s_p, 4'h5, "deb2");
    chk(s_s, 4'h9, "subst");
    chk({s_v, s_o}, 5'h15, "ohpin");
    oct(2, 0, 4'h3, 0); chk(s_p, 4'h3, "deb3");
    apb(0, 12'h0502, 0); chk(rd, 32'h0000_0003, "array");
    $display("signaling done");
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      results;
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 0;
    t_regs; t_codes; t_mw; t_pat; t_sig;
    results;
  end
endmodule
